// [rtl/gcisc_device.sv]
// device end of the signalling channel: samples the highway, validates
// commands over two frames and sends indications back.
// assumes the highway pins come from another clock domain.
`timescale 1ns/1ps
`default_nettype none
module gcisc_device (
    input wire logic ref_clk_i,                // 200 MHz clock
    input wire logic rst_i,                    // async reset, high
    gcisc_if.dev link,                         // highway pins
    input wire logic line_threshold_interrupt_i, // threshold event level
    input wire logic dropout_detect_flag_i,    // drop-out level
    input wire logic int_pin_i,                // interrupt pin level
    input wire logic [7:0] line_voltage_status_i, // line voltage status
    input wire logic ground_detect_status_i,   // ground detect level
    output logic onhook_line_monitor_o,        // on-hook monitor control
    output logic ground_detect_enable_o,       // ground detect enable
    output logic ring_ground_control_o,        // ring ground control
    output logic offhook_control_o,            // off-hook control
    output logic [7:0] line_hook_control_o,    // hook control register view
    output logic [7:0] line_fault_status_o,    // fault status register view
    output logic cmd_change_o,                 // pulse on validated change
    output logic [1:0] dn_hs_o,                // last downstream {mr, mx}
    output logic end_of_message_o              // pulse on end of message
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic dcl_prev_q;
    logic dcl_s;
    logic fsc_s;
    logic drx_s;
    logic rise;
    logic fall;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            dcl_prev_q <= 1'b0;
        end else begin
            sync1_q <= {link.highway_receive_line, link.fsc, link.dcl};
            sync2_q <= sync1_q;
            dcl_prev_q <= sync2_q[0];
        end
    end

    assign dcl_s = sync2_q[0];
    assign fsc_s = sync2_q[1];
    assign drx_s = sync2_q[2];
    assign rise = dcl_s & ~dcl_prev_q;
    assign fall = ~dcl_s & dcl_prev_q;

    // ------------------------------------------------------------
    // bit position within the subframe
    // ------------------------------------------------------------
    logic [4:0] idx_q;
    logic [4:0] idx_next;
    logic locked_q;

    assign idx_next = fsc_s ? gcisc_pkg::BIT_FIRST : 5'(idx_q + 5'h01);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            idx_q <= gcisc_pkg::BIT_LAST;
            locked_q <= 1'b0;
        end else if (rise) begin
            idx_q <= idx_next;
            if (fsc_s) begin
                locked_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // receive slot
    // ------------------------------------------------------------
    logic [7:0] rx_sh_q;
    logic frame_done_q;
    logic [3:0] rx_cmd;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_sh_q <= 8'hff;
            frame_done_q <= 1'b0;
        end else begin
            frame_done_q <= rise && locked_q && idx_next == gcisc_pkg::SC_LAST;
            if (rise && idx_next >= gcisc_pkg::SC_FIRST) begin
                rx_sh_q <= {rx_sh_q[6:0], drx_s};
            end
        end
    end

    // reserved top positions are dropped before validation
    assign rx_cmd = rx_sh_q[gcisc_pkg::SC_W-1-(gcisc_pkg::CI_W-gcisc_pkg::CMD_W) -: gcisc_pkg::CMD_W];

    // ------------------------------------------------------------
    // two-frame command validation
    // ------------------------------------------------------------
    logic [3:0] prim_q;
    logic [3:0] sec_q;
    logic sec_valid_q;
    logic change_q;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prim_q <= gcisc_pkg::CMD_RESET;
            sec_q <= gcisc_pkg::CMD_RESET;
            sec_valid_q <= 1'b0;
            change_q <= 1'b0;
        end else begin
            change_q <= 1'b0;
            if (frame_done_q) begin
                if (rx_cmd == prim_q) begin
                    sec_valid_q <= 1'b0;
                end else if (sec_valid_q && rx_cmd == sec_q) begin
                    prim_q <= sec_q;
                    sec_valid_q <= 1'b0;
                    change_q <= 1'b1;
                end else begin
                    sec_q <= rx_cmd;
                    sec_valid_q <= 1'b1;
                end
            end
        end
    end

    assign onhook_line_monitor_o = prim_q[gcisc_pkg::RX_ONHOOK_LINE_MONITOR];
    assign ground_detect_enable_o = prim_q[gcisc_pkg::RX_GROUND_DETECT_ENABLE];
    assign ring_ground_control_o = prim_q[gcisc_pkg::RX_RG];
    assign offhook_control_o = prim_q[gcisc_pkg::RX_OH];
    assign cmd_change_o = change_q;

    // register views at 8-bit addresses for the monitor engine
    always_comb begin
        line_hook_control_o = 8'h00;
        line_hook_control_o[gcisc_pkg::LHC_ONHOOK_LINE_MONITOR_BIT] = prim_q[gcisc_pkg::RX_ONHOOK_LINE_MONITOR];
        line_hook_control_o[gcisc_pkg::LHC_OH_BIT] = prim_q[gcisc_pkg::RX_OH];
    end

    // data outputs come from flops, so the fault view lags its input by one cycle
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            line_fault_status_o <= 8'h00;
        end else begin
            line_fault_status_o <= 8'h00;
            line_fault_status_o[gcisc_pkg::LFS_DOD_BIT] <= dropout_detect_flag_i;
        end
    end

    // ------------------------------------------------------------
    // downstream handshake and end of message
    // ------------------------------------------------------------
    logic [1:0] hs_q;
    logic [1:0] idle_cnt_q;
    logic eom_q;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hs_q <= gcisc_pkg::HS_IDLE;
            idle_cnt_q <= 2'h0;
            eom_q <= 1'b0;
        end else begin
            eom_q <= 1'b0;
            if (frame_done_q) begin
                hs_q <= rx_sh_q[1:0];
                if (rx_sh_q[1:0] != gcisc_pkg::HS_IDLE) begin
                    idle_cnt_q <= 2'h0;
                end else if (idle_cnt_q < gcisc_pkg::EOM_FRAMES) begin
                    idle_cnt_q <= 2'(idle_cnt_q + 2'h1);
                    eom_q <= 2'(idle_cnt_q + 2'h1) == gcisc_pkg::EOM_FRAMES;
                end
            end
        end
    end

    assign dn_hs_o = hs_q;
    assign end_of_message_o = eom_q;

    // ------------------------------------------------------------
    // transmit slot
    // ------------------------------------------------------------
    logic [7:0] ind_byte;
    logic [7:0] tx_sh_q;
    logic dtx_q;
    logic dtx_oe_q;

    // inputs share this clock, so they are sampled without synchronisers
    always_comb begin
        ind_byte = 8'h00;
        ind_byte[2+gcisc_pkg::TX_RSV] = gcisc_pkg::TX_RSV_VAL;
        ind_byte[2+gcisc_pkg::TX_CVI] = line_threshold_interrupt_i;
        ind_byte[2+gcisc_pkg::TX_DOD] = dropout_detect_flag_i;
        ind_byte[2+gcisc_pkg::TX_INT] = int_pin_i;
        ind_byte[2+gcisc_pkg::TX_BATT] = line_voltage_status_i[gcisc_pkg::LVS_BATT_BIT];
        ind_byte[2+gcisc_pkg::TX_TGD] = ground_detect_status_i;
        ind_byte[1:0] = gcisc_pkg::HS_IDLE; // monitor engine absent: stays idle
    end

    // data changes on the falling edge so the host samples it settled
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_sh_q <= 8'hff;
            dtx_q <= 1'b1;
            dtx_oe_q <= 1'b0;
        end else if (fall) begin
            if (locked_q && idx_q == gcisc_pkg::SC_PRE) begin
                tx_sh_q <= {ind_byte[6:0], 1'b1};
                dtx_q <= ind_byte[7];
                dtx_oe_q <= 1'b1;
            end else if (locked_q && idx_q >= gcisc_pkg::SC_FIRST && idx_q < gcisc_pkg::SC_LAST) begin
                tx_sh_q <= {tx_sh_q[6:0], 1'b1};
                dtx_q <= tx_sh_q[7];
                dtx_oe_q <= 1'b1;
            end else begin
                dtx_q <= 1'b1;
                dtx_oe_q <= 1'b0;
            end
        end
    end

    assign link.dtx_o = dtx_q;
    assign link.dtx_oe = dtx_oe_q;
endmodule
`default_nettype wire

// [common/gcisc_pkg.sv]
// shared constants for the signalling-channel link: frame layout,
// command/indication bit positions, register map and timing.
// assumes a 200 MHz reference clock on both ends.
package gcisc_pkg;
    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam int IDX_W = 5;
    localparam logic [4:0] BIT_FIRST = 5'h00;
    localparam logic [4:0] BIT_LAST = 5'h1f;
    localparam logic [4:0] SC_PRE = 5'h17;
    localparam logic [4:0] SC_FIRST = 5'h18;
    localparam logic [4:0] SC_LAST = 5'h1f;
    localparam int SC_W = 8;
    localparam int CI_W = 6;
    localparam logic [1:0] HS_IDLE = 2'h3;
    // ------------------------------------------------------------
    // command positions (position n is bit n-1)
    // ------------------------------------------------------------
    localparam int CMD_W = 4;
    localparam int RX_ONHOOK_LINE_MONITOR = 3;
    localparam int RX_GROUND_DETECT_ENABLE = 2;
    localparam int RX_RG = 1;
    localparam int RX_OH = 0;
    localparam logic [3:0] CMD_RESET = 4'h0;
    // ------------------------------------------------------------
    // indication positions
    // ------------------------------------------------------------
    localparam int TX_RSV = 5;
    localparam int TX_CVI = 4;
    localparam int TX_DOD = 3;
    localparam int TX_INT = 2;
    localparam int TX_BATT = 1;
    localparam int TX_TGD = 0;
    localparam logic TX_RSV_VAL = 1'b0;
    localparam int LVS_BATT_BIT = 7;
    // ------------------------------------------------------------
    // device register map, 8-bit register addresses
    // ------------------------------------------------------------
    localparam int REG_ADDR_W = 8;
    localparam logic [7:0] REG_LINE_HOOK = 8'h05;
    localparam logic [7:0] REG_LINE_FAULT = 8'h13;
    localparam int LHC_ONHOOK_LINE_MONITOR_BIT = 3;
    localparam int LHC_OH_BIT = 0;
    localparam int LFS_DOD_BIT = 1;
    // ------------------------------------------------------------
    // host register map
    // ------------------------------------------------------------
    localparam logic [7:0] HREG_CTRL = 8'h00;
    localparam logic [7:0] HREG_IND = 8'h01;
    localparam logic [7:0] HREG_IRQ_STAT = 8'h02;
    localparam logic [7:0] HREG_IRQ_MASK = 8'h03;
    localparam logic [7:0] HREG_EOM = 8'h04;
    localparam logic [7:0] CTRL_RESET = 8'hc0;
    localparam int IRQ_W = 2;
    localparam int IRQ_IND_CHG = 0;
    localparam int IRQ_EOM_DONE = 1;
    localparam logic [1:0] EOM_FRAMES = 2'h2;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int REF_NS = 5;
    localparam int LINK_HALF_NS = 24;
    localparam int LINK_HALF_CYC = (LINK_HALF_NS + REF_NS - 1) / REF_NS;
endpackage

// [common/gcisc_if.sv]
// highway pins between host and device.
// transmit line is open drain with a pull-up resolved here.
`timescale 1ns/1ps
`default_nettype none
interface gcisc_if;
    logic dcl;
    logic fsc;
    logic highway_receive_line;
    logic dtx_o;
    logic dtx_oe;
    logic highway_transmit_line;

    assign highway_transmit_line = dtx_oe ? dtx_o : 1'b1;

    modport dev (input dcl, input fsc, input highway_receive_line, input highway_transmit_line, output dtx_o, output dtx_oe);
    modport host (output dcl, output fsc, output highway_receive_line, input highway_transmit_line);
endinterface
`default_nettype wire

// [rtl/gcisc_host.sv]
// host end of the signalling channel: makes the highway clock and
// frame sync, sends commands every frame, collects indications.
// assumes a register master on the same clock.
`timescale 1ns/1ps
`default_nettype none
module gcisc_host #(
    parameter int HALF_CYC = gcisc_pkg::LINK_HALF_CYC // ref cycles per half bit
) (
    input wire logic ref_clk_i,       // 200 MHz clock
    input wire logic rst_i,           // async reset, high
    gcisc_if.host link,               // highway pins
    input wire logic [7:0] addr_i,    // register address
    input wire logic [7:0] wdata_i,   // write data
    input wire logic wr_i,            // write strobe
    input wire logic rd_i,            // read strobe
    output logic [7:0] rdata_o,       // read data, cycle after rd_i
    output logic irq_o                // level interrupt
);
    // ------------------------------------------------------------
    // clock divider and bit counter
    // ------------------------------------------------------------
    logic [7:0] div_q;
    logic dcl_q;
    logic fall_evt;
    logic [4:0] cnt_q;
    logic [4:0] cnt_next;

    assign fall_evt = dcl_q && div_q == 8'(HALF_CYC - 1);
    assign cnt_next = 5'(cnt_q + 5'h01);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= 8'h00;
            dcl_q <= 1'b0;
        end else if (div_q == 8'(HALF_CYC - 1)) begin
            div_q <= 8'h00;
            dcl_q <= ~dcl_q;
        end else begin
            div_q <= 8'(div_q + 8'h01);
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic [5:0] ind_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic [1:0] irq_set;
    logic [1:0] eom_left_q;
    logic eom_req;

    assign eom_req = wr_i && addr_i == gcisc_pkg::HREG_EOM;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= gcisc_pkg::CTRL_RESET;
            irq_mask_q <= 2'h0;
        end else if (wr_i && addr_i == gcisc_pkg::HREG_CTRL) begin
            ctrl_q <= wdata_i;
        end else if (wr_i && addr_i == gcisc_pkg::HREG_IRQ_MASK) begin
            irq_mask_q <= wdata_i[1:0];
        end
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_stat_q <= 2'h0;
        end else if (wr_i && addr_i == gcisc_pkg::HREG_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~wdata_i[1:0]) | irq_set;
        end else begin
            irq_stat_q <= irq_stat_q | irq_set;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                gcisc_pkg::HREG_CTRL: rdata_o <= ctrl_q;
                gcisc_pkg::HREG_IND: rdata_o <= {2'h0, ind_q};
                gcisc_pkg::HREG_IRQ_STAT: rdata_o <= {6'h00, irq_stat_q};
                gcisc_pkg::HREG_IRQ_MASK: rdata_o <= {6'h00, irq_mask_q};
                gcisc_pkg::HREG_EOM: rdata_o <= {6'h00, eom_left_q};
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    assign irq_o = |(irq_stat_q & irq_mask_q);

    // ------------------------------------------------------------
    // frame engine
    // ------------------------------------------------------------
    logic [1:0] sync_q;
    logic [7:0] tx_sh_q;
    logic [7:0] rx_sh_q;
    logic fsc_q;
    logic drx_q;
    logic [7:0] slot;

    // command repeats every frame, so a change held for two frames or more is seen twice at least
    assign slot = {ctrl_q[5:0], (eom_left_q != 2'h0) ? gcisc_pkg::HS_IDLE : ctrl_q[7:6]};

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_q <= 2'h3;
        end else begin
            sync_q <= {sync_q[0], link.highway_transmit_line};
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= gcisc_pkg::BIT_LAST;
            fsc_q <= 1'b0;
            drx_q <= 1'b1;
            tx_sh_q <= 8'hff;
            rx_sh_q <= 8'hff;
            ind_q <= 6'h00;
            eom_left_q <= 2'h0;
            irq_set <= 2'h0;
        end else begin
            irq_set <= 2'h0;
            if (eom_req) begin
                eom_left_q <= gcisc_pkg::EOM_FRAMES;
            end
            if (fall_evt) begin
                cnt_q <= cnt_next;
                fsc_q <= cnt_next == gcisc_pkg::BIT_FIRST;
                if (cnt_q >= gcisc_pkg::SC_FIRST) begin
                    rx_sh_q <= {rx_sh_q[6:0], sync_q[1]};
                end
                if (cnt_q == gcisc_pkg::SC_LAST) begin
                    ind_q <= rx_sh_q[6:1];
                    irq_set[gcisc_pkg::IRQ_IND_CHG] <= rx_sh_q[6:1] != ind_q;
                end
                if (cnt_next == gcisc_pkg::SC_FIRST) begin
                    drx_q <= slot[7];
                    tx_sh_q <= {slot[6:0], 1'b1};
                    if (eom_left_q != 2'h0 && !eom_req) begin
                        eom_left_q <= 2'(eom_left_q - 2'h1);
                        irq_set[gcisc_pkg::IRQ_EOM_DONE] <= eom_left_q == 2'h1;
                    end
                end else if (cnt_next > gcisc_pkg::SC_FIRST) begin
                    drx_q <= tx_sh_q[7];
                    tx_sh_q <= {tx_sh_q[6:0], 1'b1};
                end else begin
                    drx_q <= 1'b1;
                end
            end
        end
    end

    assign link.dcl = dcl_q;
    assign link.fsc = fsc_q;
    assign link.highway_receive_line = drx_q;
endmodule
`default_nettype wire

// [dv/gcisc_monitor.sv]
// pin-level checks on the highway between the host and device ends.
// assumes dcl is made by the host from ref_clk_i, so it is sampled directly.
`timescale 1ns/1ps
`default_nettype none
module gcisc_monitor #(
    parameter int HALF_CYC = gcisc_pkg::LINK_HALF_CYC // ref cycles per half bit
) (
    input wire logic ref_clk_i, // 200 MHz clock
    input wire logic rst_i,     // async reset, high
    input wire logic dcl_i,     // link clock
    input wire logic fsc_i,     // frame sync
    input wire logic drx_i,     // host to device data
    input wire logic dev_dtx_i, // device data
    input wire logic dtx_oe_i,  // device drive enable
    input wire logic dtx_i      // resolved transmit line
);
    logic dcl_q, seen_q, rise;
    logic [4:0] bit_q, cur;
    logic [7:0] hi_q;

    assign rise = dcl_i & ~dcl_q;
    assign cur = fsc_i ? 5'h00 : bit_q + 5'h01;

    // ------------------------------------------------------------
    // bit position, counted at each link clock rise
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dcl_q <= 1'b0;
            seen_q <= 1'b0;
            bit_q <= 5'h00;
            hi_q <= 8'h00;
        end else begin
            dcl_q <= dcl_i;
            hi_q <= dcl_i ? hi_q + 8'h01 : 8'h00;
            if (rise) begin
                bit_q <= cur;
                seen_q <= seen_q | fsc_i;
            end
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    a_frame_len: assert property (rise && fsc_i && seen_q |-> bit_q == 5'h1f)
        else $error("frame is not 32 bits long");
    a_slot_driven: assert property (rise && seen_q && cur >= 5'h18 |-> dtx_oe_i)
        else $error("device not driving in its slot");
    a_idle_released: assert property (rise && seen_q && cur < 5'h18 |-> !dtx_oe_i && dtx_i)
        else $error("device drives outside its slot");
    a_rsv_low: assert property (rise && seen_q && cur == 5'h18 |-> !dtx_i && !dev_dtx_i)
        else $error("reserved indication not low");
    a_hs_idle: assert property (rise && seen_q && cur >= 5'h1e |-> dtx_i)
        else $error("upstream handshake bits not idle");
    a_bit_held: assert property (dcl_i && dcl_q |-> $stable(dtx_i))
        else $error("transmit bit changed while clock high");
    a_oe_on_time: assert property ($rose(dtx_oe_i) |-> !dcl_i && bit_q == 5'h17)
        else $error("drive started at wrong bit");
    a_oe_off_time: assert property ($fell(dtx_oe_i) |-> !dcl_i && bit_q == 5'h1f)
        else $error("drive ended at wrong bit");
    a_sync_at_low: assert property ($changed(fsc_i) || $changed(drx_i) |-> !dcl_i)
        else $error("host changed sync or data while clock high");
    a_dcl_half: assert property ($fell(dcl_i) |-> hi_q == 8'(HALF_CYC))
        else $error("link clock high phase wrong length");
endmodule
`default_nettype wire

// [dv/test_gci_command_indicate_channel.sv]
// self-checking bench: host and device joined by the highway interface.
// assumes the host register map and slot layout of the shared package.
`timescale 1ns/1ps
`default_nettype none
module test_gci_command_indicate_channel;
    logic ref_clk_i, rst_i, wr_i, rd_i, irq_o, thr, dropout_detect_flag, intp, gnd, chg, end_of_message;
    logic onhook_line_monitor, ground_detect_enable, rg, oh;
    logic [7:0] addr_i, wdata_i, rdata_o, line_voltage_status, lhc, lfs, c, s, d, pc, pe;
    logic [3:0] prev;
    logic [1:0] hs;
    int err_total, checks, n_chg, n_eom;
    logic [15:0] rows [9] = '{16'h0000, 16'h0110, 16'h0308, 16'h0f04, 16'h3f02,
                              16'h0801, 16'h041f, 16'h0200, 16'h0015};

    gcisc_if link_if();
    gcisc_host gcisc_host_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link_if), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
    gcisc_device gcisc_device_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link_if),
        .line_threshold_interrupt_i(thr), .dropout_detect_flag_i(dropout_detect_flag), .int_pin_i(intp),
        .line_voltage_status_i(line_voltage_status), .ground_detect_status_i(gnd), .onhook_line_monitor_o(onhook_line_monitor),
        .ground_detect_enable_o(ground_detect_enable), .ring_ground_control_o(rg), .offhook_control_o(oh),
        .line_hook_control_o(lhc), .line_fault_status_o(lfs), .cmd_change_o(chg), .dn_hs_o(hs),
        .end_of_message_o(end_of_message));
    gcisc_monitor gcisc_monitor_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .dcl_i(link_if.dcl),
        .fsc_i(link_if.fsc), .drx_i(link_if.highway_receive_line), .dev_dtx_i(link_if.dtx_o), .dtx_oe_i(link_if.dtx_oe),
        .dtx_i(link_if.highway_transmit_line));

    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i) begin
        n_chg += int'(chg === 1'b1);
        n_eom += int'(end_of_message === 1'b1);
    end

    // ------------------------------------------------------------
    // bus and compare helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        @(negedge ref_clk_i);
        v = rdata_o;
    endtask

    task automatic frames(input int n);
        repeat (n) @(posedge link_if.fsc);
        @(posedge ref_clk_i);
    endtask

    task automatic final_report;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs about 20k cycles
    initial begin
        #250us;
        err_total++;
        final_report();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_i, wr_i, rd_i, thr, dropout_detect_flag, intp, gnd} = 7'h40;
        {addr_i, wdata_i, line_voltage_status} = 24'h000000;
        err_total = 0;
        checks = 0;
        prev = 4'h0;
        repeat (20) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd_reg(gcisc_pkg::HREG_CTRL, d);
        chk(d, 8'hc0, "ctrl reset value");
        foreach (rows[i]) begin
            c = rows[i][15:8];
            s = rows[i][7:0];
            pc = 8'(n_chg);
            @(posedge ref_clk_i);
            {thr, dropout_detect_flag, intp, gnd} <= {s[4:2], s[0]};
            line_voltage_status <= {s[1], 7'h2a};
            wr_reg(gcisc_pkg::HREG_CTRL, 8'hc0 | c);
            frames(4);
            chk({4'h0, onhook_line_monitor, ground_detect_enable, rg, oh}, {4'h0, c[3:0]}, "controls");
            chk(8'(n_chg) - pc, {7'h0, c[3:0] != prev}, "change pulses");
            chk(lhc, {4'h0, c[3], 2'h0, c[0]}, "hook register view");
            chk(lfs, {6'h0, s[3], 1'b0}, "fault register view");
            rd_reg(gcisc_pkg::HREG_IND, d);
            chk(d, {3'h0, s[4:0]}, "indications");
            prev = c[3:0];
        end
        // one-frame glitch, then two differing candidates in a row
        @(posedge link_if.fsc);
        pc = 8'(n_chg);
        wr_reg(gcisc_pkg::HREG_CTRL, 8'hc5);
        @(posedge link_if.fsc);
        wr_reg(gcisc_pkg::HREG_CTRL, 8'hc0);
        frames(3);
        chk(8'(n_chg) - pc, 8'h00, "glitch ignored");
        chk({4'h0, onhook_line_monitor, ground_detect_enable, rg, oh}, 8'h00, "controls kept");
        @(posedge link_if.fsc);
        wr_reg(gcisc_pkg::HREG_CTRL, 8'hc1);
        @(posedge link_if.fsc);
        wr_reg(gcisc_pkg::HREG_CTRL, 8'hc6);
        frames(3);
        chk(8'(n_chg) - pc, 8'h01, "single commit");
        chk({4'h0, onhook_line_monitor, ground_detect_enable, rg, oh}, 8'h06, "second candidate wins");
        rd_reg(8'h7f, d);
        chk(d, 8'h00, "unmapped read");
        wr_reg(8'h7f, 8'h3f);
        rd_reg(gcisc_pkg::HREG_CTRL, d);
        chk(d, 8'hc6, "unmapped write ignored");
        // interrupt: raise while masked, unmask, clear
        wr_reg(gcisc_pkg::HREG_IRQ_MASK, 8'h00);
        wr_reg(gcisc_pkg::HREG_IRQ_STAT, 8'h03);
        @(posedge ref_clk_i);
        intp <= 1'b0;
        frames(4);
        chk({7'h0, irq_o}, 8'h00, "masked irq");
        rd_reg(gcisc_pkg::HREG_IND, d);
        chk(d, 8'h11, "interrupt pin mirrored");
        rd_reg(gcisc_pkg::HREG_IRQ_STAT, d);
        chk(d & 8'h01, 8'h01, "indication change status");
        wr_reg(gcisc_pkg::HREG_IRQ_MASK, 8'h03);
        @(negedge ref_clk_i);
        chk({7'h0, irq_o}, 8'h01, "unmasked irq");
        wr_reg(gcisc_pkg::HREG_IRQ_STAT, 8'h01);
        @(negedge ref_clk_i);
        chk({7'h0, irq_o}, 8'h00, "cleared irq");
        // handshake bits carried, then end of message
        wr_reg(gcisc_pkg::HREG_CTRL, 8'h46);
        frames(3);
        chk({6'h0, hs}, 8'h01, "handshake carried");
        wr_reg(gcisc_pkg::HREG_CTRL, 8'h06);
        frames(3);
        pe = 8'(n_eom);
        wr_reg(gcisc_pkg::HREG_EOM, 8'h01);
        frames(4);
        chk(8'(n_eom) - pe, 8'h01, "end of message seen");
        rd_reg(gcisc_pkg::HREG_IRQ_STAT, d);
        chk(d & 8'h02, 8'h02, "end of message status");
        chk({7'h0, irq_o}, 8'h01, "end of message irq");
        // reset in mid-run returns to the idle command state
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (20) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(negedge ref_clk_i);
        chk({onhook_line_monitor, ground_detect_enable, rg, oh, 1'b0, irq_o, hs}, 8'h03, "reset state");
        pc = 8'(n_chg);
        wr_reg(gcisc_pkg::HREG_CTRL, 8'hc1);
        frames(4);
        chk({4'h0, onhook_line_monitor, ground_detect_enable, rg, oh}, 8'h01, "command after reset");
        chk(8'(n_chg) - pc, 8'h01, "one change after reset");
        final_report();
    end
endmodule
`default_nettype wire
